// File: rtl/egp_pad_cell.sv
`timescale 1ns/10ps
module egp_pad_cell
	import egp_pkg::*;
(
	input  wire logic alt_sel,
	input  wire logic gpio_dir,
	input  wire logic gpio_level,
	input  wire logic alt_out,
	input  wire logic alt_oe,
	output logic      pad_out,
	output logic      pad_oe
);

	////////////////////////////////////////////////////////////////////////////
	// pad owner: port bit or serial function
	always_comb begin
		if (alt_sel) begin
			pad_out = alt_out;
			pad_oe  = alt_oe;
		end else begin
			pad_out = gpio_level;
			pad_oe  = gpio_dir;
		end
	end

endmodule // egp_pad_cell

// File: rtl/egp_pkg.sv
package egp_pkg;

	////////////////////////////////////////////////////////////////////////////
	// widths
	localparam int EGP_PORT_W = 8;
	localparam int EGP_DATA_W = 16;
	localparam int EGP_ADDR_W = 16;

	////////////////////////////////////////////////////////////////////////////
	// register map, peripheral word addresses
	localparam logic [EGP_ADDR_W-1:0] EGP_PIN_DIRECTION_ADDR = 16'h3400;
	localparam logic [EGP_ADDR_W-1:0] EGP_PIN_LEVEL_ADDR     = 16'h3401;

	////////////////////////////////////////////////////////////////////////////
	// reset values and field positions
	localparam logic [EGP_PORT_W-1:0] EGP_DIR_RESET      = 8'h00;
	localparam logic [EGP_DATA_W-1:0] EGP_RDATA_IDLE     = 16'h0000;
	localparam int                    EGP_BIT_THREE      = 3;
	localparam int                    EGP_BIT_FIVE       = 5;
	localparam int                    EGP_STRAP_BIT      = 7;
	localparam logic [EGP_PORT_W-1:0] EGP_SHARED_MASK    = 8'h28;

	////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic                  sel;
		logic                  wr;
		logic [EGP_ADDR_W-1:0] addr;
		logic [EGP_DATA_W-1:0] wdata;
	} egp_bus_req_t;

	typedef struct packed {
		logic                  ack;
		logic [EGP_DATA_W-1:0] rdata;
	} egp_bus_rsp_t;

	typedef struct packed {
		logic clk_out;
		logic clk_oe;
		logic fs_out;
		logic fs_oe;
	} egp_serial_drive_t;

	////////////////////////////////////////////////////////////////////////////
	// address decode
	function automatic logic egp_hit(
		input logic [EGP_ADDR_W-1:0] addr,
		input logic [EGP_ADDR_W-1:0] offset
	);
		return addr == offset;
	endfunction

endpackage

// File: rtl/egp_port.sv
`timescale 1ns/10ps
// How it works
// R1 - eight pins, bit 0 lowest, bit 7 highest
// R2 - both registers read and written over bus
// R3 - direction register decoded at 0x3400
// R4 - level register decoded at 0x3401
// R5 - pads of bits 3, 5 shared with serial
// R6 - strap low: shared pads are port bits
// R7 - strap high: shared pads serve serial port
// R8 - pad function latched at reset release, held
// R9 - eight direction bits, cleared by reset
// R10 - direction 0: driver off, pin is input
// R11 - direction 1: driver on, pin is output
// R12 - input pin reads its level
// R13 - output pin driven from level bit
// R14 - after reset level bits show pin levels
// R15 - upper byte reads zero, writes ignored
module egp_port
	import egp_pkg::*;
#(
	parameter int PORT_W = EGP_PORT_W,
	parameter int DATA_W = EGP_DATA_W
)
(
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	input  wire egp_bus_req_t      bus_req,
	output egp_bus_rsp_t           bus_rsp,
	input  wire logic [PORT_W-1:0] pad_in,
	output logic      [PORT_W-1:0] pad_out,
	output logic      [PORT_W-1:0] pad_oe,
	input  wire egp_serial_drive_t serial2_drive,
	output logic                   serial2_transmit_clock_in,
	output logic                   serial2_transmit_frame_sync_in,
	output logic                   serial_mode
);

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [PORT_W-1:0] pin_direction;
	logic [PORT_W-1:0] pin_level;
	logic [PORT_W-1:0] next_pin_direction;
	logic [PORT_W-1:0] next_pin_level;
	logic              next_serial_mode;
	egp_bus_rsp_t      next_bus_rsp;
	logic              wr_dir;
	logic              wr_level;
	logic              rd_req;
	logic [PORT_W-1:0] alt_sel;
	logic [PORT_W-1:0] alt_out;
	logic [PORT_W-1:0] alt_oe;

	////////////////////////////////////////////////////////////////////////////
	// bus decode
	always_comb begin
		wr_dir   = bus_req.sel && bus_req.wr
			&& egp_hit(bus_req.addr, EGP_PIN_DIRECTION_ADDR); // [R3]
		wr_level = bus_req.sel && bus_req.wr
			&& egp_hit(bus_req.addr, EGP_PIN_LEVEL_ADDR); // [R4]
		rd_req   = bus_req.sel && !bus_req.wr;
	end

	////////////////////////////////////////////////////////////////////////////
	// next values
	always_comb begin
		next_pin_direction = pin_direction;
		next_pin_level     = pin_level;
		next_serial_mode   = serial_mode;
		next_bus_rsp       = '0;
		next_bus_rsp.rdata = EGP_RDATA_IDLE;
		if (!rst_n) begin
			next_pin_direction = EGP_DIR_RESET; // [R9]
			next_pin_level     = pad_in; // [R14]
			next_serial_mode   = pad_in[EGP_STRAP_BIT]; // [R6] [R7] [R8]
		end else begin
			if (wr_dir) begin
				next_pin_direction = bus_req.wdata[PORT_W-1:0]; // [R2] [R9] [R15]
			end
			for (int k = 0; k < PORT_W; k++) begin
				if (!pin_direction[k]) begin
					next_pin_level[k] = pad_in[k]; // [R12]
				end else if (wr_level) begin
					next_pin_level[k] = bus_req.wdata[k]; // [R2] [R13]
				end
			end
			if (bus_req.sel) begin
				next_bus_rsp.ack = 1'b1;
			end
			if (rd_req && egp_hit(bus_req.addr, EGP_PIN_DIRECTION_ADDR)) begin
				next_bus_rsp.rdata = {{(DATA_W-PORT_W){1'b0}}, pin_direction}; // [R15]
			end else if (rd_req && egp_hit(bus_req.addr, EGP_PIN_LEVEL_ADDR)) begin
				next_bus_rsp.rdata = {{(DATA_W-PORT_W){1'b0}}, pin_level}; // [R12] [R15]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers; reset overrides the clock enable
	always_ff @(posedge core_clk) begin
		if (!rst_n || ce) begin
			pin_direction <= next_pin_direction;
			pin_level     <= next_pin_level;
			serial_mode   <= next_serial_mode;
			bus_rsp       <= next_bus_rsp;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pads
	always_comb begin
		alt_sel = '0;
		alt_out = '0;
		alt_oe  = '0;
		alt_sel[EGP_BIT_THREE] = serial_mode; // [R5]
		alt_sel[EGP_BIT_FIVE]  = serial_mode; // [R5]
		alt_out[EGP_BIT_THREE] = serial2_drive.clk_out;
		alt_oe[EGP_BIT_THREE]  = serial2_drive.clk_oe;
		alt_out[EGP_BIT_FIVE]  = serial2_drive.fs_out;
		alt_oe[EGP_BIT_FIVE]   = serial2_drive.fs_oe;
		serial2_transmit_clock_in      = pad_in[EGP_BIT_THREE];
		serial2_transmit_frame_sync_in = pad_in[EGP_BIT_FIVE];
	end

	generate
		for (genvar g = 0; g < PORT_W; g++) begin : g_pad // [R1]
			egp_pad_cell u_cell (
				.alt_sel    (alt_sel[g]),
				.gpio_dir   (pin_direction[g]), // [R10] [R11]
				.gpio_level (pin_level[g]), // [R13]
				.alt_out    (alt_out[g]),
				.alt_oe     (alt_oe[g]),
				.pad_out    (pad_out[g]),
				.pad_oe     (pad_oe[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	logic [PORT_W-1:0] port_only;
	assign port_only = ~(serial_mode ? EGP_SHARED_MASK : {PORT_W{1'b0}});

	AST_DIR_WRITE: assert property ( // [R3]
		ce && wr_dir |=> pin_direction == $past(bus_req.wdata[PORT_W-1:0])
	) else $error("direction write not stored");

	AST_LEVEL_WRITE: assert property ( // [R4]
		ce && wr_level |=>
			(pin_level & $past(pin_direction))
			== ($past(bus_req.wdata[PORT_W-1:0]) & $past(pin_direction))
	) else $error("level write not stored on output bits");

	AST_READ_DIR: assert property ( // [R2]
		ce && rd_req && bus_req.addr == EGP_PIN_DIRECTION_ADDR
		|=> bus_rsp.ack && bus_rsp.rdata[PORT_W-1:0] == $past(pin_direction)
	) else $error("direction read wrong");

	AST_READ_LEVEL: assert property ( // [R12]
		ce && rd_req && bus_req.addr == EGP_PIN_LEVEL_ADDR
		|=> bus_rsp.ack && bus_rsp.rdata[PORT_W-1:0] == $past(pin_level)
	) else $error("level read wrong");

	AST_RESERVED_ZERO: assert property ( // [R15]
		bus_rsp.rdata[DATA_W-1:PORT_W] == '0
	) else $error("upper byte not zero");

	AST_UNMAPPED: assert property ( // [R2]
		ce && rd_req && bus_req.addr != EGP_PIN_DIRECTION_ADDR
		&& bus_req.addr != EGP_PIN_LEVEL_ADDR
		|=> bus_rsp.ack && bus_rsp.rdata == EGP_RDATA_IDLE
	) else $error("unmapped read not zero");

	AST_ACK_ONE: assert property ( // [R2]
		ce && !bus_req.sel |=> !bus_rsp.ack
	) else $error("answer without request");

	AST_INPUT_SAMPLE: assert property ( // [R12]
		ce |=> (pin_level & ~$past(pin_direction))
			== ($past(pad_in) & ~$past(pin_direction))
	) else $error("input pin not sampled");

	AST_OUTPUT_DRIVE: assert property ( // [R11]
		((pad_oe & port_only) == (pin_direction & port_only))
		&& ((pad_out & pin_direction & port_only)
			== (pin_level & pin_direction & port_only))
	) else $error("output driver wrong");

	AST_INPUT_RELEASE: assert property ( // [R10]
		(pad_oe & ~pin_direction & port_only) == '0
	) else $error("input pin driven");

	AST_STRAP_CAPTURE: assert property ( // [R8]
		$rose(rst_n) |-> serial_mode == $past(pad_in[EGP_STRAP_BIT])
	) else $error("strap not captured at release");

	AST_STRAP_HOLD: assert property ( // [R8]
		$past(rst_n) |-> $stable(serial_mode)
	) else $error("pad function changed");

	AST_SERIAL_PADS: assert property ( // [R7]
		serial_mode |-> pad_oe[EGP_BIT_THREE] == serial2_drive.clk_oe
			&& pad_out[EGP_BIT_THREE] == serial2_drive.clk_out
			&& pad_oe[EGP_BIT_FIVE] == serial2_drive.fs_oe
			&& pad_out[EGP_BIT_FIVE] == serial2_drive.fs_out
	) else $error("serial pads not routed");

	AST_PORT_PADS: assert property ( // [R6]
		!serial_mode |-> pad_oe[EGP_BIT_THREE] == pin_direction[EGP_BIT_THREE]
			&& pad_out[EGP_BIT_THREE] == pin_level[EGP_BIT_THREE]
			&& pad_oe[EGP_BIT_FIVE] == pin_direction[EGP_BIT_FIVE]
			&& pad_out[EGP_BIT_FIVE] == pin_level[EGP_BIT_FIVE]
	) else $error("shared pads not port bits");

	AST_FREEZE: assert property ( // [R9]
		!ce ##1 rst_n |-> $stable(pin_direction) && $stable(pin_level)
	) else $error("state moved while disabled");

endmodule // egp_port

// File: tb/egp_board.sv
`timescale 1ns/10ps
module egp_board
	import egp_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic [7:0]  pad_out,
	input  wire logic [7:0]  pad_oe,
	input  wire logic [7:0]  ext_val,
	input  wire logic [7:0]  ext_en,
	input  wire logic        tx_on,
	output logic      [7:0]  pad_in,
	output egp_serial_drive_t sdrive
);
	logic tick = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// serial clock only runs while transmitting
	always @(posedge core_clk) begin
		tick <= tx_on ? ~tick : 1'b0;
	end
	assign sdrive = '{clk_out: tick, clk_oe: tx_on, fs_out: ~tick, fs_oe: tx_on};

	////////////////////////////////////////////////////////////////////////////
	// undriven pads float high through board pull-ups
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule // egp_board

// File: tb/egp_port_test.sv
`timescale 1ns/10ps
module egp_port_test;
	import egp_pkg::*;
	logic              core_clk;
	logic              rst_n;
	logic              ce;
	logic              tx_on;
	egp_bus_req_t      req;
	egp_bus_rsp_t      rsp;
	logic [7:0]        pad_in;
	logic [7:0]        pad_out;
	logic [7:0]        pad_oe;
	logic [7:0]        ext_val;
	logic [7:0]        ext_en;
	egp_serial_drive_t sdrive;
	logic              sclk_in;
	logic              sfs_in;
	logic              serial_mode;
	logic [15:0]       rd;
	int                n_mismatch = 0;
	int                total_checks = 0;
	int                cycles = 0;

	egp_port DUT (
		.core_clk                       (core_clk),
		.rst_n                          (rst_n),
		.ce                             (ce),
		.bus_req                        (req),
		.bus_rsp                        (rsp),
		.pad_in                         (pad_in),
		.pad_out                        (pad_out),
		.pad_oe                         (pad_oe),
		.serial2_drive                  (sdrive),
		.serial2_transmit_clock_in      (sclk_in),
		.serial2_transmit_frame_sync_in (sfs_in),
		.serial_mode                    (serial_mode)
	);
	egp_board board (
		.core_clk (core_clk),
		.pad_out  (pad_out),
		.pad_oe   (pad_oe),
		.ext_val  (ext_val),
		.ext_en   (ext_en),
		.tx_on    (tx_on),
		.pad_in   (pad_in),
		.sdrive   (sdrive)
	);

	////////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles > 2000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic complete_run;
		if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// one request, answered one edge later; a spare edge keeps requests apart
	task automatic bus(input logic wr, input logic [15:0] addr, input logic [15:0] wd);
		req = '{sel: 1'b1, wr: wr, addr: addr, wdata: wd};
		@(posedge core_clk);
		#1;
		req.sel = 1'b0;
		check(16'(rsp.ack), 16'h0001);
		rd = rsp.rdata;
		@(posedge core_clk);
		#1;
		check(16'(rsp.ack), 16'h0000);
	endtask

	task automatic do_reset(input logic strap);
		rst_n = 1'b0;
		ext_val[7] = strap;
		repeat (8) @(posedge core_clk);
		#1;
		rst_n = 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		ce = 1'b1;
		tx_on = 1'b0;
		ext_en = 8'hff;
		ext_val = 8'h5a;
		req = '0;
		do_reset(1'b0);
		check(16'(serial_mode), 16'h0000);
		check(16'(pad_oe), 16'h0000);
		bus(1'b0, EGP_PIN_DIRECTION_ADDR, 16'h0000);
		check(rd, 16'h0000);
		bus(1'b0, EGP_PIN_LEVEL_ADDR, 16'h0000);
		check(rd, 16'h005a);
		bus(1'b1, EGP_PIN_DIRECTION_ADDR, 16'hff0f);
		bus(1'b1, EGP_PIN_LEVEL_ADDR, 16'hffa5);
		check(16'(pad_oe), 16'h000f);
		check(16'(pad_out & pad_oe), 16'h0005);
		bus(1'b0, EGP_PIN_DIRECTION_ADDR, 16'h0000);
		check(rd, 16'h000f);
		bus(1'b0, EGP_PIN_LEVEL_ADDR, 16'h0000);
		check(rd, 16'h0055);
		ext_val = 8'h3a;
		@(posedge core_clk);
		#1;
		bus(1'b0, EGP_PIN_LEVEL_ADDR, 16'h0000);
		check(rd, 16'h0035);
		bus(1'b0, 16'h3402, 16'h0000);
		check(rd, 16'h0000);
		// clock enable low: request not taken, pads not sampled
		ce = 1'b0;
		ext_val = 8'hc3;
		req = '{sel: 1'b1, wr: 1'b1, addr: EGP_PIN_DIRECTION_ADDR, wdata: 16'h00ff};
		repeat (2) @(posedge core_clk);
		#1;
		check(16'(rsp.ack), 16'h0000);
		check(16'(pad_oe), 16'h000f);
		ce = 1'b1;
		bus(1'b0, EGP_PIN_LEVEL_ADDR, 16'h0000);
		check(rd, 16'h0035);
		bus(1'b0, EGP_PIN_DIRECTION_ADDR, 16'h0000);
		check(rd, 16'h000f);
		do_reset(1'b1);
		check(16'(serial_mode), 16'h0001);
		ext_val = 8'h08;
		bus(1'b1, EGP_PIN_DIRECTION_ADDR, 16'h0028);
		check(16'(serial_mode), 16'h0001);
		check(16'(pad_oe & 8'h28), 16'h0000);
		check(16'({sfs_in, sclk_in}), 16'h0001);
		tx_on = 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		check(16'(pad_oe & 8'h28), 16'h0028);
		check(16'({pad_out[5], pad_out[3]}), 16'({sdrive.fs_out, sdrive.clk_out}));
		tx_on = 1'b0;
		do_reset(1'b0);
		check(16'(serial_mode), 16'h0000);
		check(16'(pad_oe), 16'h0000);
		complete_run();
	end
endmodule // egp_port_test
